// ---- inc/tspc_cfg.svh ----
`ifndef TSPC_CFG_SVH
`define TSPC_CFG_SVH
// register indices, byte address is index times four
`define TSPC_IDX_TP_LATCH  6'h00
`define TSPC_IDX_TP_LEVEL  6'h01
`define TSPC_IDX_TP_DIR    6'h02
`define TSPC_IDX_TP_DRIVE  6'h03
`define TSPC_IDX_TP_PULLEN 6'h04
`define TSPC_IDX_TP_PULLSL 6'h05
`define TSPC_IDX_SP_LATCH  6'h08
`define TSPC_IDX_SP_LEVEL  6'h09
`define TSPC_IDX_SP_DIR    6'h0a
`define TSPC_IDX_SP_DRIVE  6'h0b
`define TSPC_IDX_SP_PULLEN 6'h0c
`define TSPC_IDX_SP_PULLSL 6'h0d
`define TSPC_IDX_SP_OPEN   6'h0e
// address field split
`define TSPC_ADDR_W   8
`define TSPC_IDX_HI   7
`define TSPC_IDX_LO   2
// reset values
`define TSPC_RST_TP   4'h0
`define TSPC_RST_SP   8'h00
`define TSPC_RST_SP_PULLEN 8'hff
`define TSPC_RST_WORD 32'h0000_0000
`define TSPC_ZERO_LO  4'h0
`define TSPC_ZERO_HI  24'h00_0000
// serial pin positions
`define TSPC_SP_UART1_TX 3
`define TSPC_SP_UART1_RX 2
`define TSPC_SP_UART0_TX 1
`define TSPC_SP_UART0_RX 0
`define TSPC_SP_SPI_HI   7
`define TSPC_SP_SPI_LO   4
`endif

// ---- inc/tspc_pkg.sv ----
package tspc_pkg;
    typedef logic [5:0] tspc_idx_t;
    typedef logic [7:0] tspc_byte_t;
    typedef logic [3:0] tspc_nib_t;
endpackage : tspc_pkg

// ---- verilog/tspc_top.sv ----
// Function
// - enabled output compare forces its timer pin to output
// - direction bit keeps value under compare, regains control after
// - input capture leaves direction bit in control, timer sees level
// - timer direction holds bits 7..4, one means output
// - latch and level read-back may lag five cycles after direction
// - drive bit selects reduced drive on outputs, ignored on inputs
// - timer pull enable acts on inputs only, all off after reset
// - timer pull select one pull-down, zero pull-up, when enabled
// - serial latch reads latch for outputs, pin level for inputs
// - enabled spi owns serial pins 7..4 with its own direction
// - uarts own pins 3..0, transmit output, receive input
// - enabled uart ignores matching direction bits on its pins
// - disabled spi or uart returns control to direction bits
// - serial pin level reads actual pins, writes ignored
// - serial pull enable acts on input or open-drain, on at reset
// - serial pull select: pull-down input, pull-up input or open-drain
// - open-drain drives low only, also for spi and uart outputs
// - timer pin level reads actual pins, writes ignored
// - registers decoded at fixed offsets from a chip-level base
`timescale 1ns/1ps
`include "tspc_cfg.svh"

module tspc_top
    import tspc_pkg::*;
#(
    parameter int TP_W = 4,
    parameter int SP_W = 8
) (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [3:0]  tp_pin_i,
    output logic      [3:0]  tp_pin_o,
    output logic      [3:0]  tp_pin_oe_o,
    output logic      [3:0]  tp_reduced_drive_o,
    output logic      [3:0]  tp_pull_en_o,
    output logic      [3:0]  tp_pull_down_o,
    input  wire logic [3:0]  oc_enable_i,
    input  wire logic [3:0]  oc_level_i,
    output logic      [3:0]  tp_capture_level_o,
    input  wire logic [7:0]  sp_pin_i,
    output logic      [7:0]  sp_pin_o,
    output logic      [7:0]  sp_pin_oe_o,
    output logic      [7:0]  sp_reduced_drive_o,
    output logic      [7:0]  sp_pull_en_o,
    output logic      [7:0]  sp_pull_down_o,
    input  wire logic        spi_enable_i,
    input  wire logic [3:0]  spi_dir_i,
    input  wire logic [3:0]  spi_out_i,
    input  wire logic        uart0_tx_en_i,
    input  wire logic        uart0_tx_i,
    input  wire logic        uart0_rx_en_i,
    input  wire logic        uart1_tx_en_i,
    input  wire logic        uart1_tx_i,
    input  wire logic        uart1_rx_en_i,
    output logic      [7:0]  sp_level_o
);

    generate
        if (TP_W != 4 || SP_W != 8) begin : g_bad_width
            $error("tspc_top: port widths are fixed at 4 and 8");
        end
    endgenerate

    // read-back: latch for outputs, pin for inputs
    function automatic tspc_byte_t port_read(
        input tspc_byte_t latch,
        input tspc_byte_t level,
        input tspc_byte_t dir
    );
        port_read = (latch & dir) | (level & ~dir);
    endfunction : port_read

    // configuration registers
    tspc_nib_t  tp_latch;
    tspc_nib_t  tp_dir;
    tspc_nib_t  tp_drive;
    tspc_nib_t  tp_pullen;
    tspc_nib_t  tp_pullsl;
    tspc_byte_t sp_latch;
    tspc_byte_t sp_dir;
    tspc_byte_t sp_drive;
    tspc_byte_t sp_pullen;
    tspc_byte_t sp_pullsl;
    tspc_byte_t sp_open;

    // pin synchronisers, timer pins in the upper nibble
    logic [11:0] sync_a;
    logic [11:0] sync_b;
    logic [11:0] sync_c;
    logic [11:0] pin_level;

    // bus decode
    tspc_idx_t  idx;
    logic       req;
    logic       wr_go;
    logic       wr_lane;
    tspc_byte_t wbyte;
    logic [31:0] next_readdata;

    // effective pin control
    tspc_nib_t  next_tp_oe;
    tspc_nib_t  next_tp_out;
    tspc_byte_t next_sp_dir;
    tspc_byte_t next_sp_out;

    assign idx     = avs_address_i[`TSPC_IDX_HI:`TSPC_IDX_LO];
    assign req     = avs_read_i | avs_write_i;
    assign wr_go   = avs_write_i & ~avs_waitrequest_o;
    assign wr_lane = wr_go & avs_byteenable_i[0];
    assign wbyte   = avs_writedata_i[7:0];

    // one wait cycle, answer on the second edge
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        next_readdata = `TSPC_RST_WORD;
        case (idx)
            `TSPC_IDX_TP_LATCH: begin
                next_readdata[7:0] = port_read(
                    {tp_latch, `TSPC_ZERO_LO},
                    {pin_level[11:8], `TSPC_ZERO_LO},
                    {tp_dir, `TSPC_ZERO_LO});
            end
            `TSPC_IDX_TP_LEVEL: begin
                next_readdata[7:0] =
                    {pin_level[11:8], `TSPC_ZERO_LO};
            end
            `TSPC_IDX_TP_DIR: begin
                next_readdata[7:0] = {tp_dir, `TSPC_ZERO_LO};
            end
            `TSPC_IDX_TP_DRIVE: begin
                next_readdata[7:0] = {tp_drive, `TSPC_ZERO_LO};
            end
            `TSPC_IDX_TP_PULLEN: begin
                next_readdata[7:0] = {tp_pullen, `TSPC_ZERO_LO};
            end
            `TSPC_IDX_TP_PULLSL: begin
                next_readdata[7:0] = {tp_pullsl, `TSPC_ZERO_LO};
            end
            `TSPC_IDX_SP_LATCH: begin
                next_readdata[7:0] = port_read(sp_latch,
                    pin_level[7:0], sp_dir);
            end
            `TSPC_IDX_SP_LEVEL: begin
                next_readdata[7:0] = pin_level[7:0];
            end
            `TSPC_IDX_SP_DIR: begin
                next_readdata[7:0] = sp_dir;
            end
            `TSPC_IDX_SP_DRIVE: begin
                next_readdata[7:0] = sp_drive;
            end
            `TSPC_IDX_SP_PULLEN: begin
                next_readdata[7:0] = sp_pullen;
            end
            `TSPC_IDX_SP_PULLSL: begin
                next_readdata[7:0] = sp_pullsl;
            end
            `TSPC_IDX_SP_OPEN: begin
                next_readdata[7:0] = sp_open;
            end
            default: begin
                next_readdata = `TSPC_RST_WORD;
            end
        endcase
    end

    // read data captured in the wait cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= `TSPC_RST_WORD;
        end else if (avs_read_i & avs_waitrequest_o) begin
            avs_readdata_o <= next_readdata;
        end
    end

    // timer port registers, low nibble not stored
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_latch <= `TSPC_RST_TP;
        end else if (wr_lane && idx == `TSPC_IDX_TP_LATCH) begin
            tp_latch <= wbyte[7:4];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_dir <= `TSPC_RST_TP;
        end else if (wr_lane && idx == `TSPC_IDX_TP_DIR) begin
            tp_dir <= wbyte[7:4];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_drive <= `TSPC_RST_TP;
        end else if (wr_lane && idx == `TSPC_IDX_TP_DRIVE) begin
            tp_drive <= wbyte[7:4];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_pullen <= `TSPC_RST_TP;
        end else if (wr_lane && idx == `TSPC_IDX_TP_PULLEN) begin
            tp_pullen <= wbyte[7:4];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_pullsl <= `TSPC_RST_TP;
        end else if (wr_lane && idx == `TSPC_IDX_TP_PULLSL) begin
            tp_pullsl <= wbyte[7:4];
        end
    end

    // serial port registers, level register has no storage
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_latch <= `TSPC_RST_SP;
        end else if (wr_lane && idx == `TSPC_IDX_SP_LATCH) begin
            sp_latch <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_dir <= `TSPC_RST_SP;
        end else if (wr_lane && idx == `TSPC_IDX_SP_DIR) begin
            sp_dir <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_drive <= `TSPC_RST_SP;
        end else if (wr_lane && idx == `TSPC_IDX_SP_DRIVE) begin
            sp_drive <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_pullen <= `TSPC_RST_SP_PULLEN;
        end else if (wr_lane && idx == `TSPC_IDX_SP_PULLEN) begin
            sp_pullen <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_pullsl <= `TSPC_RST_SP;
        end else if (wr_lane && idx == `TSPC_IDX_SP_PULLSL) begin
            sp_pullsl <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_open <= `TSPC_RST_SP;
        end else if (wr_lane && idx == `TSPC_IDX_SP_OPEN) begin
            sp_open <= wbyte;
        end
    end

    // three-stage pin sync, change taken when b and c agree
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= {tp_pin_i, sp_pin_i};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_filter
            always_ff @(posedge core_clk_i) begin
                if (sys_rst_i) begin
                    pin_level[gi] <= 1'b0;
                end else if (sync_b[gi] == sync_c[gi]) begin
                    pin_level[gi] <= sync_c[gi];
                end
            end
        end
    endgenerate

    // timer pin ownership
    always_comb begin
        next_tp_oe  = oc_enable_i | tp_dir;
        next_tp_out = (oc_enable_i & oc_level_i)
                    | (~oc_enable_i & tp_latch);
    end

    // serial pin ownership
    always_comb begin
        next_sp_dir = sp_dir;
        next_sp_out = sp_latch;
        if (spi_enable_i) begin
            next_sp_dir[`TSPC_SP_SPI_HI:`TSPC_SP_SPI_LO] =
                spi_dir_i;
            next_sp_out[`TSPC_SP_SPI_HI:`TSPC_SP_SPI_LO] =
                spi_out_i;
        end
        if (uart1_tx_en_i) begin
            next_sp_dir[`TSPC_SP_UART1_TX] = 1'b1;
            next_sp_out[`TSPC_SP_UART1_TX] = uart1_tx_i;
        end
        if (uart1_rx_en_i) begin
            next_sp_dir[`TSPC_SP_UART1_RX] = 1'b0;
        end
        if (uart0_tx_en_i) begin
            next_sp_dir[`TSPC_SP_UART0_TX] = 1'b1;
            next_sp_out[`TSPC_SP_UART0_TX] = uart0_tx_i;
        end
        if (uart0_rx_en_i) begin
            next_sp_dir[`TSPC_SP_UART0_RX] = 1'b0;
        end
    end

    // timer pad controls
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_pin_o           <= `TSPC_RST_TP;
            tp_pin_oe_o        <= `TSPC_RST_TP;
            tp_reduced_drive_o <= `TSPC_RST_TP;
        end else begin
            tp_pin_o           <= next_tp_out;
            tp_pin_oe_o        <= next_tp_oe;
            tp_reduced_drive_o <= tp_drive & next_tp_oe;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_pull_en_o   <= `TSPC_RST_TP;
            tp_pull_down_o <= `TSPC_RST_TP;
        end else begin
            tp_pull_en_o   <= tp_pullen & ~next_tp_oe;
            tp_pull_down_o <= tp_pullsl & tp_pullen
                            & ~next_tp_oe;
        end
    end

    // serial pad controls
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_pin_o           <= `TSPC_RST_SP;
            sp_pin_oe_o        <= `TSPC_RST_SP;
            sp_reduced_drive_o <= `TSPC_RST_SP;
        end else begin
            sp_pin_o    <= next_sp_out;
            sp_pin_oe_o <= next_sp_dir
                         & ~(sp_open & next_sp_out);
            sp_reduced_drive_o <= sp_drive & next_sp_dir;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_pull_en_o   <= `TSPC_RST_SP;
            sp_pull_down_o <= `TSPC_RST_SP;
        end else begin
            sp_pull_en_o <= sp_pullen
                & (~next_sp_dir | (sp_open & ~sp_pullsl));
            sp_pull_down_o <= sp_pullen & sp_pullsl
                & ~next_sp_dir;
        end
    end

    // filtered levels to the peripherals
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tp_capture_level_o <= `TSPC_RST_TP;
            sp_level_o         <= `TSPC_RST_SP;
        end else begin
            tp_capture_level_o <= pin_level[11:8];
            sp_level_o         <= pin_level[7:0];
        end
    end

endmodule : tspc_top

// ---- testbench/tspc_top_assertions.sv ----
`timescale 1ns/1ps
module tspc_chk (
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic        avs_waitrequest_o,
    input wire logic [31:0] avs_readdata_o,
    input wire logic [3:0]  oc_enable_i,
    input wire logic [3:0]  oc_level_i,
    input wire logic [3:0]  tp_pin_o,
    input wire logic [3:0]  tp_pin_oe_o,
    input wire logic [3:0]  tp_reduced_drive_o,
    input wire logic [3:0]  tp_pull_en_o,
    input wire logic        spi_enable_i,
    input wire logic [3:0]  spi_dir_i,
    input wire logic        uart1_tx_en_i,
    input wire logic        uart1_tx_i,
    input wire logic        uart0_rx_en_i,
    input wire logic [7:0]  sp_pin_o,
    input wire logic [7:0]  sp_pin_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_bus_answer_once:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
            |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle");
    a_compare_forces_out:
        assert property (!$past(sys_rst_i) |->
            (tp_pin_oe_o & $past(oc_enable_i)) == $past(oc_enable_i))
        else $error("compare pin not output");
    a_compare_drives_level:
        assert property (!$past(sys_rst_i) |->
            ((tp_pin_o ^ $past(oc_level_i)) & $past(oc_enable_i)) == 4'h0)
        else $error("compare level not on pin");
    a_spi_inputs_free:
        assert property (!$past(sys_rst_i) && $past(spi_enable_i) |->
            (sp_pin_oe_o[7:4] & ~$past(spi_dir_i)) == 4'h0)
        else $error("spi input pin driven");
    a_uart_tx_low:
        assert property (!$past(sys_rst_i) &&
            $past(uart1_tx_en_i) && !$past(uart1_tx_i) |->
            sp_pin_oe_o[3] && !sp_pin_o[3])
        else $error("uart transmit low not driven");
    a_uart_rx_input:
        assert property (!$past(sys_rst_i) && $past(uart0_rx_en_i)
            |-> !sp_pin_oe_o[0])
        else $error("uart receive pin driven");
    a_reduced_on_output:
        assert property ((tp_reduced_drive_o & ~tp_pin_oe_o) == 4'h0)
        else $error("reduced drive on input");
    a_pull_off_output:
        assert property ((tp_pull_en_o & tp_pin_oe_o) == 4'h0)
        else $error("pull on driven timer pin");
    a_readdata_upper_zero:
        assert property (avs_readdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
endmodule : tspc_chk

bind tspc_top tspc_chk tspc_chk_i (.core_clk_i, .sys_rst_i, .avs_read_i,
    .avs_write_i, .avs_waitrequest_o, .avs_readdata_o, .oc_enable_i,
    .oc_level_i, .tp_pin_o, .tp_pin_oe_o, .tp_reduced_drive_o, .tp_pull_en_o,
    .spi_enable_i, .spi_dir_i, .uart1_tx_en_i, .uart1_tx_i, .uart0_rx_en_i,
    .sp_pin_o, .sp_pin_oe_o);

// ---- testbench/tspc_pad_model.sv ----
`timescale 1ns/1ps
module tspc_pad_model #(
    parameter int W = 8
) (
    input  wire logic         core_clk_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pull_en_i,
    input  wire logic [W-1:0] pull_down_i,
    input  wire logic [W-1:0] ext_en_i,
    input  wire logic [W-1:0] ext_val_i,
    output logic      [W-1:0] pin_o
);
    logic [W-1:0] flt = '0;
    // floating line shows the inverse of its last level
    always @(posedge core_clk_i) begin
        flt <= ~pin_o;
    end
    assign pin_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
        | (~oe_i & ~ext_en_i & pull_en_i & ~pull_down_i)
        | (~oe_i & ~ext_en_i & ~pull_en_i & flt);
endmodule : tspc_pad_model

// ---- testbench/tspc_top_tb.sv ----
`timescale 1ns/1ps
module tspc_top_tb
    import tspc_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'h1;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [3:0]  tp_pin_i, tp_pin_o, tp_pin_oe_o, tp_reduced_drive_o;
    logic [3:0]  tp_pull_en_o, tp_pull_down_o, tp_capture_level_o;
    logic [3:0]  oc_enable_i = 4'h0, oc_level_i = 4'h0;
    logic [3:0]  spi_dir_i = 4'h0, spi_out_i = 4'h0;
    logic        spi_enable_i = 1'b0;
    logic        uart0_tx_en_i = 1'b0, uart0_tx_i = 1'b0, uart0_rx_en_i = 1'b0;
    logic        uart1_tx_en_i = 1'b0, uart1_tx_i = 1'b0, uart1_rx_en_i = 1'b0;
    logic [7:0]  sp_pin_i, sp_pin_o, sp_pin_oe_o, sp_reduced_drive_o;
    logic [7:0]  sp_pull_en_o, sp_pull_down_o, sp_level_o;
    tspc_byte_t  ext_en = 8'h00, ext_val = 8'h00;
    int          error_cnt = 0, n_checks = 0, cyc = 0;

    tspc_top tspc_top_i (.core_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .tp_pin_i, .tp_pin_o, .tp_pin_oe_o,
        .tp_reduced_drive_o, .tp_pull_en_o, .tp_pull_down_o, .oc_enable_i,
        .oc_level_i, .tp_capture_level_o, .sp_pin_i, .sp_pin_o, .sp_pin_oe_o,
        .sp_reduced_drive_o, .sp_pull_en_o, .sp_pull_down_o, .spi_enable_i,
        .spi_dir_i, .spi_out_i, .uart0_tx_en_i, .uart0_tx_i, .uart0_rx_en_i,
        .uart1_tx_en_i, .uart1_tx_i, .uart1_rx_en_i, .sp_level_o);
    tspc_pad_model #(.W(4)) tp_pad_i (.core_clk_i, .drv_i(tp_pin_o),
        .oe_i(tp_pin_oe_o), .pull_en_i(tp_pull_en_o),
        .pull_down_i(tp_pull_down_o), .ext_en_i(4'h0), .ext_val_i(4'h0),
        .pin_o(tp_pin_i));
    tspc_pad_model #(.W(8)) sp_pad_i (.core_clk_i, .drv_i(sp_pin_o),
        .oe_i(sp_pin_oe_o), .pull_en_i(sp_pull_en_o),
        .pull_down_i(sp_pull_down_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_o(sp_pin_i));

    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // write d, or read and compare against d
    task automatic bus(input logic w, input tspc_idx_t x, input tspc_byte_t d,
                       input string nm = "reg");
        @(posedge core_clk_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= {x, 2'b00};
        avs_writedata_i <= {24'h0, d};
        do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
        if (!w) chk(nm, avs_readdata_o, {24'h0, d});
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : settle

    task automatic t_reset();
        bus(1'b0, 6'h04, 8'h00, "tp pull en");
        bus(1'b0, 6'h0c, 8'hff, "sp pull en");
        bus(1'b0, 6'h08, 8'hff, "sp pulled");
        chk("tp pull pads", tp_pull_en_o, 4'h0);
        chk("sp pull pads", sp_pull_en_o, 8'hff);
    endtask : t_reset
    task automatic t_regs();
        tspc_idx_t rw[9];
        rw = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
        foreach (rw[k]) begin
            bus(1'b1, rw[k], 8'hff);
            bus(1'b0, rw[k], (rw[k] < 6'h08) ? 8'hf0 : 8'hff);
        end
        bus(1'b1, 6'h06, 8'hff);
        bus(1'b0, 6'h06, 8'h00, "unmapped");
        settle(6);
        bus(1'b1, 6'h09, 8'hff);
        bus(1'b0, 6'h09, 8'h00, "sp level wr");
        foreach (rw[k]) bus(1'b1, rw[k], 8'h00);
    endtask : t_regs
    task automatic t_timer();
        bus(1'b1, 6'h00, 8'ha0);
        bus(1'b1, 6'h02, 8'h10);
        @(posedge core_clk_i);
        oc_enable_i <= 4'h3;
        oc_level_i <= 4'h1;
        settle(2);
        chk("oc oe", tp_pin_oe_o, 4'h3);
        chk("oc out", tp_pin_o & 4'h3, 4'h1);
        bus(1'b0, 6'h02, 8'h10, "tp dir kept");
        oc_enable_i <= 4'h0;
        settle(2);
        chk("oc off oe", tp_pin_oe_o, 4'h1);
        bus(1'b1, 6'h02, 8'hf0);
        settle(3);
        chk("tp out", tp_pin_o, 4'ha);
        chk("tp oe", tp_pin_oe_o, 4'hf);
        bus(1'b0, 6'h00, 8'ha0, "tp latch");
    endtask : t_timer
    task automatic t_pulls();
        bus(1'b1, 6'h02, 8'h00);
        bus(1'b1, 6'h04, 8'hf0);
        bus(1'b1, 6'h05, 8'h30);
        bus(1'b1, 6'h03, 8'hf0);
        settle(8);
        chk("tp pull", tp_pull_en_o, 4'hf);
        chk("tp pull dn", tp_pull_down_o, 4'h3);
        chk("tp red in", tp_reduced_drive_o, 4'h0);
        chk("capture", tp_capture_level_o, 4'hc);
        bus(1'b1, 6'h01, 8'h30);
        bus(1'b0, 6'h01, 8'hc0, "tp level");
        bus(1'b1, 6'h02, 8'hf0);
        settle(1);
        chk("tp pull out", tp_pull_en_o, 4'h0);
        chk("tp red out", tp_reduced_drive_o, 4'hf);
    endtask : t_pulls
    task automatic t_serial();
        bus(1'b1, 6'h0a, 8'h0f);
        bus(1'b1, 6'h08, 8'h05);
        bus(1'b1, 6'h0b, 8'hff);
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        settle(8);
        chk("sp red", sp_reduced_drive_o, 8'h0f);
        chk("sp level out", sp_level_o, 8'ha5);
        bus(1'b0, 6'h08, 8'ha5, "sp latch");
        bus(1'b0, 6'h09, 8'ha5, "sp level");
        {uart1_tx_en_i, uart1_rx_en_i, uart0_tx_en_i, uart0_rx_en_i} <= 4'hf;
        settle(2);
        chk("uart oe", sp_pin_oe_o[3:0], 4'ha);
        uart1_tx_i <= 1'b1;
        uart0_tx_i <= 1'b1;
        settle(2);
        chk("uart out", sp_pin_o[3:0] & 4'ha, 4'ha);
        bus(1'b1, 6'h0e, 8'h0a);
        bus(1'b1, 6'h0c, 8'h0a);
        settle(1);
        chk("od oe", sp_pin_oe_o[3:0], 4'h0);
        chk("od pull", sp_pull_en_o, 8'h0a);
        chk("od pull dn", sp_pull_down_o & 8'h0a, 8'h00);
        spi_enable_i <= 1'b1;
        spi_dir_i <= 4'h6;
        spi_out_i <= 4'h2;
        ext_en <= 8'h90;
        settle(2);
        chk("spi oe", sp_pin_oe_o[7:4], 4'h6);
        chk("spi out", sp_pin_o & 8'h60, 8'h20);
        spi_enable_i <= 1'b0;
        {uart1_tx_en_i, uart1_rx_en_i, uart0_tx_en_i, uart0_rx_en_i} <= 4'h0;
        settle(2);
        chk("gpio oe", sp_pin_oe_o, 8'h0f);
        chk("gpio out", sp_pin_o[3:0], 4'h5);
    endtask : t_serial

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_timer();
        t_pulls();
        t_serial();
        give_verdict();
    end
endmodule : tspc_top_tb
